//--- src/leb_pkg.sv
package leb_pkg;
   localparam logic [11:0] LEB_CTRL_ADDR    = 12'h000;
   localparam logic [11:0] LEB_SEL_ADDR     = 12'h004;
   localparam logic [11:0] LEB_LEN_ADDR     = 12'h008;
   localparam logic [11:0] LEB_STAT_ADDR    = 12'h00C;
   localparam logic [15:0] LEB_CTRL_RESET   = 16'h0000;
   localparam logic [15:0] LEB_CTRL_WMASK   = 16'hFC3F;
   localparam int          HI_RISE_BIT      = 15;
   localparam int          HI_FALL_BIT      = 14;
   localparam int          LO_RISE_BIT      = 13;
   localparam int          LO_FALL_BIT      = 12;
   localparam int          FAULT_BLANK_BIT  = 11;
   localparam int          CURLIM_BLANK_BIT = 10;
   localparam int          SIG_HIGH_BIT     = 5;
   localparam int          SIG_LOW_BIT      = 4;
   localparam int          HI_HIGH_BIT      = 3;
   localparam int          HI_LOW_BIT       = 2;
   localparam int          LO_HIGH_BIT      = 1;
   localparam int          LO_LOW_BIT       = 0;
   localparam int          SEL_WIDTH        = 2;
   localparam logic [1:0]  SEL_RESET        = 2'h0;
   localparam int          LEN_WIDTH        = 16;
   localparam logic [15:0] LEN_RESET        = 16'h0000;
endpackage

//--- src/sync2.sv
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;
   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

//--- src/pwm_leading_edge_blanking_control.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
//Function
// RL1: high-side rising/falling edges restart blanking counter when their enables are set.
// RL2: low-side rising/falling edges restart blanking counter when their enables are set.
// RL3: blanking masks fault and/or current-limit input per their enables.
// RL4: state blanking while high-side output high or low, per enables.
// RL5: state blanking while low-side output high or low, per enables.
// RL6: state blanking while selected blanking signal high or low, per enables.
// RL7: blanking signal source comes from a separate selection field, not this register.
module pwm_leading_edge_blanking_control
   import leb_pkg::*;
#(
   parameter int NSRC = 4
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 pwm_high_side_out,
   input  wire logic                 pwm_low_side_out,
   input  wire logic [NSRC-1:0]      blank_sources,
   input  wire logic                 fault_in,
   input  wire logic                 curlim_in,
   output logic                      fault_out,
   output logic                      curlim_out,
   output logic                      blank_active
);
   logic [15:0]          leading_edge_blank_control_q;
   logic [SEL_WIDTH-1:0] blank_signal_select_q;
   logic [LEN_WIDTH-1:0] blank_len_q;
   logic [LEN_WIDTH-1:0] cnt_q;
   logic                 hi_prev_q;
   logic                 lo_prev_q;
   logic                 hi_s;
   logic                 lo_s;
   logic                 flt_s;
   logic                 cl_s;
   logic [NSRC-1:0]      src_s;
   logic                 sig_s;
   logic                 trig;
   logic                 state_blank;
   logic                 blank;
   logic                 wr_en;
   logic                 addr_ok;

   // every signal pin crosses in through two flops; the registered outputs lag those pins by three cycles
   sync2 #(.W(NSRC + 4)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .din   ({blank_sources, curlim_in, fault_in, pwm_low_side_out, pwm_high_side_out}),
      .dout  ({src_s, cl_s, flt_s, lo_s, hi_s})
   );

   assign addr_ok = (paddr == LEB_CTRL_ADDR) || (paddr == LEB_SEL_ADDR)
                 || (paddr == LEB_LEN_ADDR) || (paddr == LEB_STAT_ADDR);
   assign wr_en   = psel && penable && pwrite && addr_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         leading_edge_blank_control_q <= LEB_CTRL_RESET;
         blank_signal_select_q        <= SEL_RESET;
         blank_len_q                  <= LEN_RESET;
      end else if (wr_en) begin
         if (paddr == LEB_CTRL_ADDR) begin
            leading_edge_blank_control_q <= pwdata[15:0] & LEB_CTRL_WMASK;
         end
         if (paddr == LEB_SEL_ADDR) begin
            blank_signal_select_q <= pwdata[SEL_WIDTH-1:0]; // RL7
         end
         if (paddr == LEB_LEN_ADDR) begin
            blank_len_q <= pwdata[LEN_WIDTH-1:0];
         end
      end
   end

   // zero-wait-state slave; unmapped addresses answer with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               LEB_CTRL_ADDR: prdata <= {16'h0000, leading_edge_blank_control_q};
               LEB_SEL_ADDR:  prdata <= {{(32 - SEL_WIDTH){1'b0}}, blank_signal_select_q};
               LEB_LEN_ADDR:  prdata <= {16'h0000, blank_len_q};
               LEB_STAT_ADDR: prdata <= {16'h0000, cnt_q};
               default:       prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_prev_q <= 1'b0;
         lo_prev_q <= 1'b0;
      end else begin
         hi_prev_q <= hi_s;
         lo_prev_q <= lo_s;
      end
   end

   assign trig =
        (leading_edge_blank_control_q[HI_RISE_BIT]  &&  hi_s && !hi_prev_q)  // RL1
     || (leading_edge_blank_control_q[HI_FALL_BIT]  && !hi_s &&  hi_prev_q)  // RL1
     || (leading_edge_blank_control_q[LO_RISE_BIT]  &&  lo_s && !lo_prev_q)  // RL2
     || (leading_edge_blank_control_q[LO_FALL_BIT]  && !lo_s &&  lo_prev_q); // RL2

   // out-of-range select reads as a low blanking signal
   assign sig_s = (32'(blank_signal_select_q) < NSRC) ? src_s[blank_signal_select_q] : 1'b0;

   assign state_blank =
        (leading_edge_blank_control_q[HI_HIGH_BIT]  &&  hi_s)   // RL4
     || (leading_edge_blank_control_q[HI_LOW_BIT]   && !hi_s)   // RL4
     || (leading_edge_blank_control_q[LO_HIGH_BIT]  &&  lo_s)   // RL5
     || (leading_edge_blank_control_q[LO_LOW_BIT]   && !lo_s)   // RL5
     || (leading_edge_blank_control_q[SIG_HIGH_BIT] &&  sig_s)  // RL6
     || (leading_edge_blank_control_q[SIG_LOW_BIT]  && !sig_s); // RL6

   // a new trigger reloads the count even mid-window, extending the blanking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= LEN_RESET;
      end else if (trig) begin
         cnt_q <= blank_len_q; // RL1 RL2
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   assign blank = trig || (cnt_q != 16'h0000) || state_blank;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_out    <= 1'b0;
         curlim_out   <= 1'b0;
         blank_active <= 1'b0;
      end else begin
         blank_active <= blank;
         fault_out    <= flt_s && !(blank && leading_edge_blank_control_q[FAULT_BLANK_BIT]); // RL3
         curlim_out   <= cl_s && !(blank && leading_edge_blank_control_q[CURLIM_BLANK_BIT]); // RL3
      end
   end
endmodule

//--- bench/leb_properties.sv
`timescale 1ns/1ps
module leb_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fault_in,
   input wire logic        fault_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_setup_answer: assert property (psel && !penable |=> pready) else $error("no answer");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
   a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
   a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
   a_err_access: assert property (pslverr |-> pready) else $error("stray error");
   a_fault_cause: assert property (fault_out |-> $past(fault_in, 3) || $past(fault_in, 4))
      else $error("fault from nothing");
endmodule
bind pwm_leading_edge_blanking_control leb_checker i_chk (.pclk, .presetn, .psel, .penable,
   .prdata, .pready, .pslverr, .fault_in, .fault_out);

//--- bench/pwm_far_end.sv
`timescale 1ns/1ps
module pwm_far_end (
   input wire logic [2:0] pins,
   output logic           pwm_high_side_out,
   output logic           pwm_low_side_out,
   output logic     [3:0] blank_sources
);
   assign pwm_low_side_out = pins[0];
   assign pwm_high_side_out = pins[1];
   // only source 1 follows pins[2], so a wrong select is caught
   assign blank_sources = {~pins[2], ~pins[2], pins[2], ~pins[2]};
endmodule

//--- bench/pwm_leading_edge_blanking_control_tb_top.sv
`timescale 1ns/1ps
module pwm_leading_edge_blanking_control_tb_top;
   import leb_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        fault_in = 1, curlim_in = 1, pready, pslverr, fault_out, curlim_out;
   logic        blank_active, pwm_high_side_out, pwm_low_side_out;
   logic [2:0]  pins = 0, seen;
   logic [3:0]  blank_sources;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   int          fails = 0, checks_done = 0;
   pwm_far_end i_far (.*);
   pwm_leading_edge_blanking_control i_dut (.*);
   initial forever #10 pclk = ~pclk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      fails += (got !== exp);
      if (got !== exp) $display("MISMATCH %0t seen %h expected %h", $time, got, exp);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (!pready);
      rd = prdata;
      check(pslverr, e);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic look(input int n);
      seen = 0;
      repeat (n) @(posedge pclk) seen |= {~curlim_out, fault_out, 1'b1} & {3{blank_active}};
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      fails++;
      conclude;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      apb(0, LEB_CTRL_ADDR, 0, 0);
      check(rd, 32'h0);
      apb(1, LEB_CTRL_ADDR, 32'hFFFF, 0);
      apb(0, LEB_CTRL_ADDR, 0, 0);
      check(rd, 32'hFC3F);
      apb(0, 12'h010, 0, 1);
      apb(1, LEB_LEN_ADDR, 32'h4, 0);
      apb(1, LEB_SEL_ADDR, 32'h1, 0);
      apb(0, LEB_LEN_ADDR, 0, 0);
      check(rd, 32'h4);
      apb(0, LEB_SEL_ADDR, 0, 0);
      check(rd, 32'h1);
      // each pass: wrong edge or idle level first, then the enabled edge or level
      for (int b = 0; b < 16; b++) begin
         if (b > 5 && b < 12) continue;
         // park the pin on the enabled side so the next move is the wrong edge
         pins[b % 12 / 2] <= b[0];
         apb(1, LEB_CTRL_ADDR, (b > 11 ? 32'h800 : 32'h400) | (32'h1 << b), 0);
         pins[b % 12 / 2] <= !b[0];
         look(6);
         look(12);
         check(seen, 0);
         pins[b % 12 / 2] <= b[0];
         look(8);
         check(seen, b > 11 ? 1 : 7);
      end
      // with both enables cleared the raw inputs pass straight through
      apb(1, LEB_CTRL_ADDR, 32'h0, 0);
      fault_in <= 0;
      repeat (6) @(posedge pclk);
      check({fault_out, curlim_out, blank_active}, 3'b010);
      fault_in <= 1;
      curlim_in <= 0;
      repeat (6) @(posedge pclk);
      check({fault_out, curlim_out, blank_active}, 3'b100);
      conclude;
   end
endmodule
